// file: rtl/oslk_pkg.sv
// Shared constants for the one-shot start link block
package oslk_pkg;
  localparam int          DATA_W        = 32;
  localparam int          FLAG_N        = 8;
  localparam int          CH1_MATCH_N   = 6;
  localparam int          ADDR_W        = 4;
  // Byte addresses of the word registers
  localparam logic [3:0]  OFS_START     = 4'h0;
  localparam logic [3:0]  OFS_LINK      = 4'h4;
  localparam logic [3:0]  OFS_MODE      = 4'h8;
  // Flag positions, letter H at the top
  localparam int          BIT_FLAG_H    = 7;
  localparam int          BIT_FLAG_G    = 6;
  localparam int          BIT_FLAG_A    = 0;
  // Reset values
  localparam logic [7:0]  RST_START     = 8'h00;
  localparam logic [7:0]  RST_LINK      = 8'h00;
  localparam logic [7:0]  RST_MODE      = 8'h00;
  localparam logic [31:0] RDATA_UNMAP   = 32'h0000_0000;
  // Byte lane that carries the 8-bit registers
  localparam int          LANE_LOW      = 0;
endpackage

// file: rtl/oslk_bus_if.sv
// Register access strobes between the bus front end and the core
`timescale 1ns/1ns
interface oslk_bus_if;
  logic                        wr_stb;
  logic [oslk_pkg::ADDR_W-1:0] addr;
  logic [oslk_pkg::DATA_W-1:0] wdata;
  logic [3:0]                  be;
  logic [oslk_pkg::DATA_W-1:0] rdata;

  modport front
  (
    output wr_stb,
    output addr,
    output wdata,
    output be,
    input  rdata
  );
  modport core
  (
    input  wr_stb,
    input  addr,
    input  wdata,
    input  be,
    output rdata
  );
endinterface

// file: rtl/oslk_avs.sv
// Avalon-MM slave front end with one wait cycle per access
`timescale 1ns/1ns
module oslk_avs
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [oslk_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [oslk_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                  byteenable,
  output logic [oslk_pkg::DATA_W-1:0]      readdata,
  output logic                             waitrequest,
  oslk_bus_if.front                        bus
);
  typedef struct packed
  {
    logic                        wait_r;
    logic [oslk_pkg::DATA_W-1:0] rdata_r;
  } oslk_avs_st_t;

  oslk_avs_st_t st_r;
  oslk_avs_st_t st_nxt;
  logic         req;

  assign req         = read | write;
  assign readdata    = st_r.rdata_r;
  assign waitrequest = st_r.wait_r;
  // Write lands only on the edge where the master sees waitrequest low
  assign bus.wr_stb  = write & ~st_r.wait_r;
  assign bus.addr    = address;
  assign bus.wdata   = writedata;
  assign bus.be      = byteenable;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.wait_r = 1'b1;
    if (req && st_r.wait_r)
    begin
      st_nxt.wait_r = 1'b0;
      if (read)
      begin
        st_nxt.rdata_r = bus.rdata;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r.wait_r  <= 1'b1;
      st_r.rdata_r <= oslk_pkg::RDATA_UNMAP;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: rtl/oslk_route.sv
// Compare-match routing onto the start flags
`timescale 1ns/1ns
module oslk_route
(
  input  wire logic [oslk_pkg::CH1_MATCH_N-1:0] ch1_match,
  input  wire logic                             ch2_match_a,
  input  wire logic                             ch2_match_b,
  input  wire logic [oslk_pkg::FLAG_N-1:0]      link_enable,
  input  wire logic [oslk_pkg::FLAG_N-1:0]      offset_mode,
  output logic [oslk_pkg::FLAG_N-1:0]           hw_set
);
  logic [oslk_pkg::FLAG_N-1:0] raw_match;

  assign raw_match = {ch2_match_b, ch2_match_a, ch1_match};

  // Plain one-shot mode ignores matches; only software starts counters
  genvar i;
  generate
    for (i = 0; i < oslk_pkg::FLAG_N; i++)
    begin : g_route
      assign hw_set[i] = raw_match[i] & link_enable[i] & offset_mode[i];
    end
  endgenerate
endmodule

// file: rtl/oslk_top.sv
// Start flags and compare link register of the one-shot down-counters
`timescale 1ns/1ns
module oslk_top
#(
  parameter int ADDR_W = oslk_pkg::ADDR_W,
  parameter int FLAG_N = oslk_pkg::FLAG_N
)
(
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST_N,
  input  wire logic [ADDR_W-1:0]                AVS_ADDRESS,
  input  wire logic                             AVS_READ,
  input  wire logic                             AVS_WRITE,
  input  wire logic [oslk_pkg::DATA_W-1:0]      AVS_WRITEDATA,
  input  wire logic [3:0]                       AVS_BYTEENABLE,
  output logic [oslk_pkg::DATA_W-1:0]           AVS_READDATA,
  output logic                                  AVS_WAITREQUEST,
  input  wire logic [oslk_pkg::CH1_MATCH_N-1:0] CH1_MATCH,
  input  wire logic                             CH2_MATCH_A,
  input  wire logic                             CH2_MATCH_B,
  input  wire logic [FLAG_N-1:0]                UNDERFLOW,
  input  wire logic                             HW_STANDBY,
  input  wire logic                             SW_STANDBY,
  output logic [FLAG_N-1:0]                     START_FLAGS
);
  // Refused at elaboration: the register map fixes both widths
  if (ADDR_W != oslk_pkg::ADDR_W || FLAG_N != oslk_pkg::FLAG_N)
  begin : g_width_check
    $error("oslk_top: address and flag widths are fixed by the register map");
  end

  typedef struct packed
  {
    logic [FLAG_N-1:0] start_flags_r;
    logic [FLAG_N-1:0] link_enable_r;
    logic [FLAG_N-1:0] offset_mode_r;
    logic              hwsb_meta_r;
    logic              hwsb_sync_r;
  } oslk_top_st_t;

  oslk_top_st_t      st_r;
  oslk_top_st_t      st_nxt;
  logic [FLAG_N-1:0] hw_set;
  logic [FLAG_N-1:0] sw_set;
  logic [FLAG_N-1:0] set_any;
  logic              standby;
  logic              lane_wr;
  logic              wr_start;
  logic              wr_link;
  logic              wr_mode;

  oslk_bus_if bus ();

  oslk_avs u_avs
  (
    .clk         (CLK_SYS),
    .rst_n       (RST_N),
    .address     (AVS_ADDRESS),
    .read        (AVS_READ),
    .write       (AVS_WRITE),
    .writedata   (AVS_WRITEDATA),
    .byteenable  (AVS_BYTEENABLE),
    .readdata    (AVS_READDATA),
    .waitrequest (AVS_WAITREQUEST),
    .bus         (bus.front)
  );

  oslk_route u_route
  (
    .ch1_match   (CH1_MATCH),
    .ch2_match_a (CH2_MATCH_A),
    .ch2_match_b (CH2_MATCH_B),
    .link_enable (st_r.link_enable_r),
    .offset_mode (st_r.offset_mode_r),
    .hw_set      (hw_set)
  );

  // The pin standby level is synchronised; the software one is on-chip logic
  assign standby = st_r.hwsb_sync_r | SW_STANDBY;

  // Registers are 8 bits wide, so only the low byte lane writes them
  assign lane_wr  = bus.wr_stb & bus.be[oslk_pkg::LANE_LOW];
  assign wr_start = lane_wr && (bus.addr == oslk_pkg::OFS_START);
  assign wr_link  = lane_wr && (bus.addr == oslk_pkg::OFS_LINK);
  assign wr_mode  = lane_wr && (bus.addr == oslk_pkg::OFS_MODE);

  // A written zero has no effect on a flag
  assign sw_set  = wr_start ? bus.wdata[FLAG_N-1:0] : '0;
  assign set_any = sw_set | hw_set;

  // Flags drive the counters directly; a counter decrements only while its flag is 1
  assign START_FLAGS = st_r.start_flags_r;

  always_comb
  begin
    bus.rdata = oslk_pkg::RDATA_UNMAP;
    unique case (bus.addr)
      oslk_pkg::OFS_START: bus.rdata[FLAG_N-1:0] = st_r.start_flags_r;
      oslk_pkg::OFS_LINK:  bus.rdata[FLAG_N-1:0] = st_r.link_enable_r;
      oslk_pkg::OFS_MODE:  bus.rdata[FLAG_N-1:0] = st_r.offset_mode_r;
      default:             bus.rdata = oslk_pkg::RDATA_UNMAP;
    endcase
  end

  always_comb
  begin
    st_nxt             = st_r;
    st_nxt.hwsb_meta_r = HW_STANDBY;
    st_nxt.hwsb_sync_r = st_r.hwsb_meta_r;
    // Set wins over the underflow clear in the same cycle
    st_nxt.start_flags_r = set_any | (st_r.start_flags_r & ~UNDERFLOW);
    if (wr_link)
    begin
      st_nxt.link_enable_r = bus.wdata[FLAG_N-1:0];
    end
    if (wr_mode)
    begin
      st_nxt.offset_mode_r = bus.wdata[FLAG_N-1:0];
    end
    // Standby overrides every set source, including a pending bus write
    if (standby)
    begin
      st_nxt.start_flags_r = oslk_pkg::RST_START;
      st_nxt.link_enable_r = oslk_pkg::RST_LINK;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      st_r.start_flags_r <= oslk_pkg::RST_START;
      st_r.link_enable_r <= oslk_pkg::RST_LINK;
      st_r.offset_mode_r <= oslk_pkg::RST_MODE;
      st_r.hwsb_meta_r   <= 1'b0;
      st_r.hwsb_sync_r   <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: tb/oslk_partner.sv
// Down-counter model that raises underflow after a run of LEN+1 cycles
`timescale 1ns/1ns
module oslk_partner
#(
  parameter int LEN = 12
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] run,
  output logic      [7:0] uflow
);
  logic [7:0][3:0] cnt;
  always_ff @(posedge clk)
    for (int i = 0; i < 8; i++)
    begin
      // Guard stops a second pulse while the flag is still clearing
      uflow[i] <= rst_n && run[i] && cnt[i] == 4'h0 && !uflow[i];
      cnt[i]   <= !run[i] ? 4'(LEN) : cnt[i] - 4'h1;
    end
endmodule

// file: tb/oslk_checker.sv
// Port assertions for the start flags and the bus answer
`timescale 1ns/1ns
module oslk_checker
#(
  parameter int ADDR_W = 4,
  parameter int FLAG_N = 8
)
(
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic              AVS_WAITREQUEST,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic [5:0]        CH1_MATCH,
  input wire logic              CH2_MATCH_A,
  input wire logic              CH2_MATCH_B,
  input wire logic [FLAG_N-1:0] UNDERFLOW,
  input wire logic              HW_STANDBY,
  input wire logic              SW_STANDBY,
  input wire logic [FLAG_N-1:0] START_FLAGS
);
  logic quiet;
  assign quiet = !AVS_WRITE && CH1_MATCH == 6'h00 && !CH2_MATCH_A && !CH2_MATCH_B;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_ack_one_cycle: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("late ack");
  a_rdata_byte: assert property (
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000) else $error("upper bits set");
  a_uflow_clears: assert property (
    quiet |=> (START_FLAGS & $past(UNDERFLOW)) == 8'h00) else $error("flag not cleared");
  // Pin standby acts two edges late because of its synchroniser
  a_flag_hold: assert property (
    quiet && UNDERFLOW == 8'h00 && !SW_STANDBY && !$past(HW_STANDBY, 2)
    |=> $stable(START_FLAGS)) else $error("flag moved");
  a_no_cause_rise: assert property (
    quiet |=> (START_FLAGS & ~$past(START_FLAGS)) == 8'h00) else $error("flag rose alone");
  a_h_route: assert property (
    $rose(START_FLAGS[7]) |-> $past(CH2_MATCH_B) || $past(AVS_WRITE)) else $error("bad H set");
  a_g_route: assert property (
    $rose(START_FLAGS[6]) |-> $past(CH2_MATCH_A) || $past(AVS_WRITE)) else $error("bad G set");
  a_standby_clr: assert property (
    SW_STANDBY |=> START_FLAGS == 8'h00) else $error("standby kept flags");
  a_pin_standby_clr: assert property (
    $past(HW_STANDBY, 2) |=> START_FLAGS == 8'h00) else $error("pin standby kept flags");
endmodule
bind oslk_top oslk_checker #(.ADDR_W(ADDR_W), .FLAG_N(FLAG_N)) CHK (.*);

// file: tb/oslk_top_tb.sv
// Self-checking bench for the one-shot start link block
`timescale 1ns/1ns
module oslk_top_tb;
  localparam int MODEL_LEN = 12;
  logic          CLK_SYS         = 1'b0;
  logic          RST_N           = 1'b0;
  logic [3:0]    AVS_ADDRESS     = 4'h0;
  logic          AVS_READ        = 1'b0;
  logic          AVS_WRITE       = 1'b0;
  logic [31:0]   AVS_WRITEDATA   = 32'h0000_0000;
  logic [3:0]    AVS_BYTEENABLE  = 4'hF;
  logic [31:0]   AVS_READDATA;
  logic          AVS_WAITREQUEST;
  logic [5:0]    CH1_MATCH       = 6'h00;
  logic          CH2_MATCH_A     = 1'b0;
  logic          CH2_MATCH_B     = 1'b0;
  logic [7:0]    UNDERFLOW;
  logic          HW_STANDBY      = 1'b0;
  logic          SW_STANDBY      = 1'b0;
  logic [7:0]    START_FLAGS;
  logic [31:0]   q;
  int            bad_count       = 0;
  int            tests_run       = 0;
  int            n;
  always #5 CLK_SYS = ~CLK_SYS;
  oslk_top DUT
  (
    .CLK_SYS         (CLK_SYS),
    .RST_N           (RST_N),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_BYTEENABLE  (AVS_BYTEENABLE),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST),
    .CH1_MATCH       (CH1_MATCH),
    .CH2_MATCH_A     (CH2_MATCH_A),
    .CH2_MATCH_B     (CH2_MATCH_B),
    .UNDERFLOW       (UNDERFLOW),
    .HW_STANDBY      (HW_STANDBY),
    .SW_STANDBY      (SW_STANDBY),
    .START_FLAGS     (START_FLAGS)
  );
  oslk_partner #(.LEN(MODEL_LEN)) MODEL
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .run   (START_FLAGS),
    .uflow (UNDERFLOW)
  );
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n >= 20)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, '0);
    chk(q, e);
  endtask
  // Matches are one-cycle pulses; flags must show them one edge later
  task automatic hit(input logic [7:0] m, input logic [7:0] e);
    @(posedge CLK_SYS);
    {CH2_MATCH_B, CH2_MATCH_A, CH1_MATCH} <= m;
    @(posedge CLK_SYS);
    {CH2_MATCH_B, CH2_MATCH_A, CH1_MATCH} <= 8'h00;
    #1;
    chk(32'(START_FLAGS), 32'(e));
  endtask
  task automatic drain;
    n = 0;
    while (START_FLAGS !== 8'h00 && n < 40)
    begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    chk(32'(START_FLAGS), '0);
  endtask
  initial
  begin
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(oslk_pkg::OFS_START, '0);
    rd(oslk_pkg::OFS_LINK, '0);
    acc(1'b1, oslk_pkg::OFS_LINK, 32'h0000_005A);
    rd(oslk_pkg::OFS_LINK, 32'h0000_005A);
    // A write without the low byte lane must leave the register alone
    AVS_BYTEENABLE <= 4'hE;
    acc(1'b1, oslk_pkg::OFS_LINK, 32'h0000_00A5);
    AVS_BYTEENABLE <= 4'hF;
    rd(oslk_pkg::OFS_LINK, 32'h0000_005A);
    rd(4'hC, '0);
    acc(1'b1, oslk_pkg::OFS_MODE, 32'h0000_00FF);
    acc(1'b1, oslk_pkg::OFS_LINK, '0);
    hit(8'hFF, 8'h00);
    acc(1'b1, oslk_pkg::OFS_LINK, 32'h0000_00FF);
    for (int i = 0; i < 8; i++)
    begin
      hit(8'h01 << i, 8'h01 << i);
      drain();
    end
    // Match lands on the very edge that samples the underflow pulse
    acc(1'b1, oslk_pkg::OFS_START, 32'h0000_0001);
    repeat (MODEL_LEN + 1) @(posedge CLK_SYS);
    CH1_MATCH <= 6'h01;
    @(posedge CLK_SYS);
    chk(32'(UNDERFLOW), 32'h0000_0001);
    CH1_MATCH <= 6'h00;
    #1;
    chk(32'(START_FLAGS), 32'h0000_0001);
    drain();
    acc(1'b1, oslk_pkg::OFS_START, 32'h0000_0081);
    rd(oslk_pkg::OFS_START, 32'h0000_0081);
    acc(1'b1, oslk_pkg::OFS_START, '0);
    rd(oslk_pkg::OFS_START, 32'h0000_0081);
    drain();
    acc(1'b1, oslk_pkg::OFS_START, 32'h0000_003C);
    @(posedge CLK_SYS);
    SW_STANDBY <= 1'b1;
    @(posedge CLK_SYS);
    SW_STANDBY <= 1'b0;
    rd(oslk_pkg::OFS_LINK, '0);
    rd(oslk_pkg::OFS_START, '0);
    // Pin standby reaches the flags through the two-stage synchroniser
    acc(1'b1, oslk_pkg::OFS_LINK, 32'h0000_000F);
    acc(1'b1, oslk_pkg::OFS_START, 32'h0000_003C);
    HW_STANDBY <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    HW_STANDBY <= 1'b0;
    #1;
    chk(32'(START_FLAGS), '0);
    rd(oslk_pkg::OFS_LINK, '0);
    rd(oslk_pkg::OFS_MODE, 32'h0000_00FF);
    // Reset in mid-run must clear what the run left behind
    acc(1'b1, oslk_pkg::OFS_LINK, 32'h0000_0033);
    acc(1'b1, oslk_pkg::OFS_START, 32'h0000_0010);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(oslk_pkg::OFS_START, '0);
    rd(oslk_pkg::OFS_LINK, '0);
    rd(oslk_pkg::OFS_MODE, '0);
    wrap_up();
  end
endmodule
